//--- src/ife_apb_phase.sv
`timescale 1ns/1ps
// one wait state: setup, access with pready low, access with pready high
module ife_apb_phase
  import ife_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // apb handshake
  input  wire logic psel_i,
  input  wire logic penable_i,
  output logic      pready_o
);

  ife_state_e state_reg;
  ife_state_e state_next;

  always_comb
  begin
    case (state_reg)
      IFE_IDLE: state_next = (psel_i && penable_i) ? IFE_ACK : IFE_IDLE;
      IFE_ACK:  state_next = IFE_IDLE;
      default:  state_next = IFE_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= IFE_IDLE;
    else
      state_reg <= state_next;
  end

  assign pready_o = (state_reg == IFE_ACK);

  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pready_o |=> !pready_o)
    else $error("pready held for more than one cycle");

endmodule : ife_apb_phase

//--- src/ife_bank_top.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ife_bank_top
  import ife_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [IFE_AW-1:0] paddr_i,
  input  wire logic [IFE_DW-1:0] pwdata_i,
  output logic      [IFE_DW-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // peripheral requests for flag bank 4, one-cycle or level
  input  wire logic [7:0]        flag4_src_i,
  // enables of bank 4 held elsewhere
  input  wire logic [7:0]        en4_i,
  // flags of banks 0 and 1 held elsewhere
  input  wire logic [IFE_RW-1:0] flag0_i,
  input  wire logic [IFE_RW-1:0] flag1_i,
  // gated requests to the cpu priority logic
  output logic      [IFE_RW-1:0] req0_o,
  output logic      [IFE_RW-1:0] req1_o,
  output logic      [7:0]        req4_o,
  // enable bank contents
  output logic      [IFE_RW-1:0] en0_o,
  output logic      [IFE_RW-1:0] en1_o,
  // interrupt
  output logic                   irq_o
);

  logic              ready_w;
  ife_sel_e          sel_w;
  logic              sample_w;
  logic              done_w;
  logic              wr_w;
  logic [7:0]        flags4_w;
  logic [7:0]        rise_w;

  logic [IFE_DW-1:0] prdata_reg;
  logic [IFE_DW-1:0] prdata_next;
  logic              slverr_reg;
  logic              slverr_next;
  logic [IFE_RW-1:0] en0_reg;
  logic [IFE_RW-1:0] en0_next;
  logic [IFE_RW-1:0] en1_reg;
  logic [IFE_RW-1:0] en1_next;
  logic [7:0]        evt_reg;
  logic [7:0]        evt_next;
  logic [7:0]        mask_reg;
  logic [7:0]        mask_next;
  logic              irq_reg;
  logic              irq_next;
  logic [IFE_RW-1:0] req0_reg;
  logic [IFE_RW-1:0] req0_next;
  logic [IFE_RW-1:0] req1_reg;
  logic [IFE_RW-1:0] req1_next;
  logic [7:0]        req4_reg;
  logic [7:0]        req4_next;

  ife_apb_phase u_phase (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pready_o  (ready_w)
  );

  assign sel_w    = ife_decode(paddr_i);
  // read data is captured in the wait cycle so that it leaves a flop
  assign sample_w = psel_i && penable_i && !ready_w;
  assign done_w   = psel_i && penable_i && ready_w;
  assign wr_w     = done_w && pwrite_i;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      if (IFE_FLAGS4_MASK[gi])
      begin : g_impl
        ife_flag_cell u_cell (
          .clk_i   (clk_i),
          .rst_n_i (rst_n_i),
          .set_i   (flag4_src_i[gi]),
          .wr_i    (wr_w && (sel_w == IFE_SEL_FLAGS4)),
          .wdata_i (pwdata_i[gi]),
          .flag_o  (flags4_w[gi]),
          .rise_o  (rise_w[gi])
        );

        flag_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
          (!flag4_src_i[gi] && !(wr_w && sel_w == IFE_SEL_FLAGS4)) |=> $stable(flags4_w[gi]))
          else $error("flag changed with no set and no write");

        flag_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
          (wr_w && sel_w == IFE_SEL_FLAGS4 && !flag4_src_i[gi]) |=> flags4_w[gi] == $past(pwdata_i[gi]))
          else $error("flag write not stored");
      end
      else
      begin : g_unimpl
        assign flags4_w[gi] = 1'b0;
        assign rise_w[gi]   = 1'b0;
      end
    end
  endgenerate

  always_comb
  begin
    prdata_next = prdata_reg;
    // the error flag stands only in the cycle in which pready is high
    slverr_next = 1'b0;
    if (sample_w)
    begin
      slverr_next = (sel_w == IFE_SEL_NONE);
      case (sel_w)
        IFE_SEL_FLAGS4:  prdata_next = {24'h000000, flags4_w};
        IFE_SEL_EN0:     prdata_next = {16'h0000, en0_reg};
        IFE_SEL_EN1:     prdata_next = {16'h0000, en1_reg};
        IFE_SEL_EVT:     prdata_next = {24'h000000, evt_reg};
        IFE_SEL_EVTMASK: prdata_next = {24'h000000, mask_reg};
        default:         prdata_next = 32'h00000000;
      endcase
    end
  end

  always_comb
  begin
    en0_next  = en0_reg;
    en1_next  = en1_reg;
    mask_next = mask_reg;
    if (wr_w && sel_w == IFE_SEL_EN0)
      en0_next = pwdata_i[15:0] & IFE_EN0_MASK;
    if (wr_w && sel_w == IFE_SEL_EN1)
      en1_next = pwdata_i[15:0] & IFE_EN1_MASK;
    if (wr_w && sel_w == IFE_SEL_EVTMASK)
      mask_next = pwdata_i[7:0] & IFE_EVT_MASK;
    // only bits the reader saw are cleared; new arrivals survive
    evt_next = evt_reg;
    if (done_w && !pwrite_i && sel_w == IFE_SEL_EVT)
      evt_next = evt_reg & ~prdata_reg[7:0];
    evt_next  = evt_next | rise_w;
    irq_next  = |(evt_next & mask_next);
    req0_next = flag0_i & en0_reg;
    req1_next = flag1_i & en1_reg;
    req4_next = flags4_w & en4_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
      en0_reg    <= IFE_RST_REG;
      en1_reg    <= IFE_RST_REG;
      evt_reg    <= IFE_RST_EVT;
      mask_reg   <= IFE_RST_EVT;
      irq_reg    <= 1'b0;
      req0_reg   <= IFE_RST_REG;
      req1_reg   <= IFE_RST_REG;
      req4_reg   <= IFE_RST_EVT;
    end
    else
    begin
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
      en0_reg    <= en0_next;
      en1_reg    <= en1_next;
      evt_reg    <= evt_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
      req0_reg   <= req0_next;
      req1_reg   <= req1_next;
      req4_reg   <= req4_next;
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = ready_w;
  assign pslverr_o = slverr_reg;
  assign en0_o     = en0_reg;
  assign en1_o     = en1_reg;
  assign irq_o     = irq_reg;
  assign req0_o    = req0_reg;
  assign req1_o    = req1_reg;
  assign req4_o    = req4_reg;

  unimp_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pready_o && !pwrite_i && sel_w == IFE_SEL_FLAGS4) |-> prdata_o[31:8] == 24'h000000 && !prdata_o[3])
    else $error("unimplemented flag bits read non-zero");

  en0_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_w && sel_w == IFE_SEL_EN0) |=> en0_o == ($past(pwdata_i[15:0]) & 16'h7fff))
    else $error("enable bank 0 write not stored");

  flag_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flags4_w[3] == 1'b0)
    else $error("flag bit 3 set");

  flag_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flag4_src_i[IFE_B_CAN_B_TX] |=> ##1 flags4_w[IFE_B_CAN_B_TX] || $past(wr_w))
    else $error("flag not set by its source");

  en0_top_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !en0_o[15])
    else $error("enable bank 0 bit 15 set");

  en1_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !en1_o[2])
    else $error("enable bank 1 bit 2 set");

  req_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req1_o == ($past(flag1_i) & $past(en1_o)))
    else $error("bank 1 request not gated by enable");

  req4_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (flag4_src_i[0] && !en4_i[0]) ##1 !en4_i[0] |=> !req4_o[0])
    else $error("disabled source forwarded");

  irq_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(evt_reg[0]) && mask_reg[0] |-> irq_o)
    else $error("unmasked event did not raise irq");

  // checks below watch the enable banks, the bus answer and the event path
  en1_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_w && sel_w == IFE_SEL_EN1) |=> en1_o == ($past(pwdata_i[15:0]) & 16'hfffb))
    else $error("enable bank 1 write not stored");

  en0_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_w && sel_w == IFE_SEL_EN0) |=> $stable(en0_o))
    else $error("enable bank 0 changed without a write");

  en1_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_w && sel_w == IFE_SEL_EN1) |=> $stable(en1_o))
    else $error("enable bank 1 changed without a write");

  en0_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pready_o && !pwrite_i && sel_w == IFE_SEL_EN0) |-> prdata_o[31:15] == 17'h00000)
    else $error("enable bank 0 empty bits read non-zero");

  en1_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pready_o && !pwrite_i && sel_w == IFE_SEL_EN1) |-> prdata_o[31:16] == 16'h0000 && !prdata_o[2])
    else $error("enable bank 1 empty bits read non-zero");

  req0_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req0_o == ($past(flag0_i) & $past(en0_o)))
    else $error("bank 0 request not gated by enable");

  req0_top_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !req0_o[15])
    else $error("bank 0 request on empty bit 15");

  req1_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !req1_o[2])
    else $error("bank 1 request on empty bit 2");

  req4_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (flags4_w[IFE_B_CAN_B_TX] && en4_i[IFE_B_CAN_B_TX]) |=> req4_o[IFE_B_CAN_B_TX])
    else $error("enabled flagged source not forwarded");

  irq_match_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_o == |(evt_reg & mask_reg))
    else $error("irq level disagrees with masked events");

  evt_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rise_w[IFE_B_PWM_FAULT_B] |=> evt_reg[IFE_B_PWM_FAULT_B])
    else $error("event bit not set by a new flag");

  evt_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (done_w && !pwrite_i && sel_w == IFE_SEL_EVT && rise_w == 8'h00) |=> (evt_reg & $past(prdata_o[7:0])) == 8'h00)
    else $error("event bits read but not cleared");

  evt_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !evt_reg[3] && !mask_reg[3])
    else $error("event or mask bit 3 set");

  mask_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_w && sel_w == IFE_SEL_EVTMASK) |=> mask_reg == ($past(pwdata_i[7:0]) & 8'hf7))
    else $error("event mask write not stored");

  unmapped_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_w && sel_w == IFE_SEL_NONE) |=> $stable(en0_o) && $stable(en1_o) && $stable(mask_reg))
    else $error("write to an unmapped address changed a register");

  slverr_ready_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pslverr_o |-> pready_o)
    else $error("slave error outside the ready cycle");

  slverr_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pready_o && sel_w == IFE_SEL_NONE) |-> pslverr_o)
    else $error("unmapped access answered without error");

  rdata_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !sample_w |=> $stable(prdata_o))
    else $error("read data changed without a read");

  ready_after_access_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pready_o |-> $past(penable_i))
    else $error("pready without a preceding access cycle");

endmodule : ife_bank_top

//--- src/ife_flag_cell.sv
`timescale 1ns/1ps
module ife_flag_cell
  import ife_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // hardware set and software write
  input  wire logic set_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  // state
  output logic      flag_o,
  output logic      rise_o
);

  logic flag_reg;
  logic flag_next;

  always_comb
  begin
    flag_next = wr_i ? wdata_i : flag_reg;
    if (set_i)
      flag_next = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign flag_o = flag_reg;
  assign rise_o = set_i && !flag_reg;

  set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (set_i && wr_i && !wdata_i) |=> flag_o)
    else $error("software clear beat hardware set");

endmodule : ife_flag_cell

//--- src/ife_pkg.sv
// How it works
// - unimplemented bits read zero and ignore writes
// - implemented bits clear at power-on reset; all but the event bits, which a read clears, are read/write
// - flag bank 4: high byte and bit 3 empty, low byte holds seven sources
// - a flag reads one once its source has requested, else zero
// - enable bank 0: bit 15 empty, bits 14..8 gate seven sources
// - enable bank 0: bits 7..0 gate eight sources
// - enable bank 1: bits 15..8 gate eight sources
// - enable bank 1: bits 7..0 gate sources, bit 2 empty
// - enable one passes the source request, zero blocks it
package ife_pkg;

  localparam int          IFE_AW          = 8;
  localparam int          IFE_DW          = 32;
  localparam int          IFE_RW          = 16;

  // byte offsets on the apb bus
  localparam logic [7:0]  IFE_OFF_FLAGS4  = 8'h00;
  localparam logic [7:0]  IFE_OFF_EN0     = 8'h04;
  localparam logic [7:0]  IFE_OFF_EN1     = 8'h08;
  localparam logic [7:0]  IFE_OFF_EVT     = 8'h0c;
  localparam logic [7:0]  IFE_OFF_EVTMASK = 8'h10;

  // implemented-bit masks
  localparam logic [15:0] IFE_FLAGS4_MASK = 16'h00f7;
  localparam logic [15:0] IFE_EN0_MASK    = 16'h7fff;
  localparam logic [15:0] IFE_EN1_MASK    = 16'hfffb;
  localparam logic [7:0]  IFE_EVT_MASK    = 8'hf7;

  localparam logic [15:0] IFE_RST_REG     = 16'h0000;
  localparam logic [7:0]  IFE_RST_EVT     = 8'h00;

  // flag bank 4 bit positions
  localparam int          IFE_B_PWM_FAULT_B = 0;
  localparam int          IFE_B_UART_A_ERR  = 1;
  localparam int          IFE_B_UART_B_ERR  = 2;
  localparam int          IFE_B_DMA_CH6     = 4;
  localparam int          IFE_B_DMA_CH7     = 5;
  localparam int          IFE_B_CAN_A_TX    = 6;
  localparam int          IFE_B_CAN_B_TX    = 7;

  typedef enum logic [0:0] {
    IFE_IDLE = 1'b0,
    IFE_ACK  = 1'b1
  } ife_state_e;

  // register selector
  typedef enum logic [2:0] {
    IFE_SEL_NONE    = 3'h0,
    IFE_SEL_FLAGS4  = 3'h1,
    IFE_SEL_EN0     = 3'h2,
    IFE_SEL_EN1     = 3'h3,
    IFE_SEL_EVT     = 3'h4,
    IFE_SEL_EVTMASK = 3'h5
  } ife_sel_e;

  function automatic ife_sel_e ife_decode(input logic [7:0] addr);
    case (addr)
      IFE_OFF_FLAGS4:  ife_decode = IFE_SEL_FLAGS4;
      IFE_OFF_EN0:     ife_decode = IFE_SEL_EN0;
      IFE_OFF_EN1:     ife_decode = IFE_SEL_EN1;
      IFE_OFF_EVT:     ife_decode = IFE_SEL_EVT;
      IFE_OFF_EVTMASK: ife_decode = IFE_SEL_EVTMASK;
      default:         ife_decode = IFE_SEL_NONE;
    endcase
  endfunction : ife_decode

endpackage : ife_pkg

//--- tb/ife_bank_top_tb.sv
`timescale 1ns/1ps
module ife_bank_top_tb;
  import ife_pkg::*;
  logic        clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, fire, hold, src, en4, req4;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] flag0, flag1, req0, req1, en0, en1;
  logic        e;
  int          num_errors, cmp_count, cyc;
  logic [7:0]  offs [3] = '{8'h00, 8'h04, 8'h08};
  logic [31:0] impl [3] = '{32'h0000_00f7, 32'h0000_7fff, 32'h0000_fffb};

  ife_bank_top i_ife_bank_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .flag4_src_i(src), .en4_i(en4), .flag0_i(flag0), .flag1_i(flag1),
    .req0_o(req0), .req1_o(req1), .req4_o(req4), .en0_o(en0), .en1_o(en1), .irq_o(irq));
  ife_src_model i_ife_src_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .hold_i(hold),
    .src_o(src));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // a hung handshake ends here rather than spinning forever
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rdc

  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i);
    fire <= v;
    @(posedge clk_i);
    fire <= 8'h00;
    repeat (3) @(posedge clk_i);
  endtask : pulse

  initial
  begin
    {rst_n_i, psel, penable, pwrite, paddr, pwdata, fire, hold, en4, flag0, flag1} = '0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rdc(offs[i], 32'h0);
      apb(1'b1, offs[i], 32'hffff_ffff);
      rdc(offs[i], impl[i]);
    end
    check({16'h0, en0}, 32'h0000_7fff);
    check({16'h0, en1}, 32'h0000_fffb);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, offs[i], 32'h0);
      rdc(offs[i], 32'h0);
    end
    apb(1'b1, 8'h14, 32'hffff_ffff);
    check({31'h0, e}, 32'h1);
    rdc(8'h14, 32'h0);
    flag0 <= 16'hffff;
    flag1 <= 16'hffff;
    apb(1'b1, 8'h04, 32'h0000_5a81);
    apb(1'b1, 8'h08, 32'h0000_a5c6);
    pulse(8'hff);
    check({24'h0, req4}, 32'h0);
    rdc(8'h00, 32'h0000_00f7);
    en4 <= 8'h3c;
    repeat (2) @(posedge clk_i);
    check({24'h0, req4}, 32'h0000_0034);
    check({16'h0, req0}, 32'h0000_5a81);
    check({16'h0, req1}, 32'h0000_a5c2);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h10, 32'h0000_00ff);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h1);
    rdc(8'h0c, 32'h0000_00f7);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    rdc(8'h00, 32'h0);
    hold <= 8'h01;
    repeat (2) @(posedge clk_i);
    apb(1'b1, 8'h00, 32'h0);
    rdc(8'h00, 32'h0000_0001);
    hold <= 8'h00;
    rdc(8'h0c, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    pulse(8'h02);
    check({31'h0, irq}, 32'h0);
    rdc(8'h0c, 32'h0000_0002);
    rdc(8'h00, 32'h0000_0002);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    check({16'h0, en0}, 32'h0);
    check({16'h0, req0}, 32'h0);
    rdc(8'h00, 32'h0);
    rdc(8'h0c, 32'h0);
    tally_and_finish();
  end
endmodule : ife_bank_top_tb

//--- tb/ife_src_model.sv
`timescale 1ns/1ps
// stands in for the peripheral request sources of flag bank 4
module ife_src_model
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // one-cycle fire and held level commands
  input  wire logic [7:0] fire_i,
  input  wire logic [7:0] hold_i,
  // request lines
  output logic      [7:0] src_o
);
  logic [7:0] pulse_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pulse_reg <= 8'h00;
    end
    else
    begin
      pulse_reg <= fire_i;
    end
  end

  // a strobe lasts one cycle; a held source keeps its line up like a real level request
  assign src_o = pulse_reg | hold_i;
endmodule : ife_src_model
